// File: hw/mpc_defs.vh
// constants for the motion command precondition checker
// assumes inclusion by hw/mpc_checker.v only
`ifndef MPC_DEFS_VH
`define MPC_DEFS_VH

// ****************************************
// register byte offsets
// ****************************************
`define MPC_OFF_CMD 8'h00
`define MPC_OFF_STAT 8'h04
`define MPC_OFF_AXST 8'h08
`define MPC_OFF_ERR0 8'h10

// ****************************************
// command field positions
// ****************************************
`define MPC_CMD_OP_LSB 0
`define MPC_CMD_OP_MSB 1
`define MPC_CMD_MAIN_LSB 4
`define MPC_CMD_MAIN_MSB 5
`define MPC_CMD_SUB_LSB 8
`define MPC_CMD_SUB_MSB 9
`define MPC_CMD_MASK_LSB 12
`define MPC_CMD_MASK_MSB 15
`define MPC_CMD_ABSVAR_BIT 16

// ****************************************
// opcodes
// ****************************************
`define MPC_OP_LINEAR 2'h1
`define MPC_OP_CONCUR 2'h2
`define MPC_OP_SPDPOS 2'h3

// ****************************************
// error codes
// ****************************************
`define MPC_E_NONE 9'h000
`define MPC_E_MAIN_NOOUT 9'd244
`define MPC_E_SUB_NOOUT 9'd245
`define MPC_E_MAIN_AUX 9'd247
`define MPC_E_SUB_AUX 9'd248
`define MPC_E_ABS_ORG_A 9'd250
`define MPC_E_ABS_ORG_B 9'd251
`define MPC_E_PAIR 9'd253
`define MPC_E_NOMOVE 9'd257
`define MPC_E_MAIN_SPD 9'd258
`define MPC_E_SUB_SPD 9'd259
`define MPC_E_CC_BUSY 9'd291
`define MPC_E_CC_NOOUT 9'd292
`define MPC_E_CC_AUX 9'd293
`define MPC_E_CC_ORG 9'd294
`define MPC_E_CC_SET 9'd296
`define MPC_E_SP_IDLE 9'd301
`define MPC_E_SP_NOTSPD 9'd302
`define MPC_E_SP_NOAMT 9'd304

`endif

// File: hw/mpc_checker.v
// precondition checker for positioning commands on four axes
// assumes a classic wishbone master and axis status inputs on clk
//
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "mpc_defs.vh"

module mpc_checker (
   // clock and reset
   input wire clk,
   input wire rst,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // axis state, same clock domain, one bit per axis
   input wire [3:0] ax_busy,
   input wire [3:0] ax_noout,
   input wire [3:0] ax_aux,
   input wire [3:0] ax_homed,
   input wire [3:0] ax_spdctl,
   input wire [3:0] ax_step_spd,
   input wire [3:0] ax_step_abs,
   input wire [3:0] ax_step_nomove,
   // command results
   output reg [3:0] ax_start_reg,
   output reg [3:0] ax_stop_reg,
   output reg [3:0] ax_switch_reg,
   output reg err_pulse_reg
);

   // ****************************************
   // registers
   // ****************************************
   reg [8:0] err_reg [0:3];
   reg [8:0] last_err_reg;
   reg [1:0] last_op_reg;
   reg cmd_reg;
   reg [16:0] cmd_word_reg;
   reg [8:0] code;
   reg [3:0] stop_set;
   reg [3:0] start_set;
   reg [3:0] switch_set;
   reg [3:0] err_axes;

   wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire [1:0] op = cmd_word_reg[`MPC_CMD_OP_MSB:`MPC_CMD_OP_LSB];
   wire [1:0] main_ax = cmd_word_reg[`MPC_CMD_MAIN_MSB:`MPC_CMD_MAIN_LSB];
   wire [1:0] sub_ax = cmd_word_reg[`MPC_CMD_SUB_MSB:`MPC_CMD_SUB_LSB];
   wire [3:0] cc_mask = cmd_word_reg[`MPC_CMD_MASK_MSB:`MPC_CMD_MASK_LSB];
   wire absvar = cmd_word_reg[`MPC_CMD_ABSVAR_BIT];

   // one-hot decode of an axis number, used for main and sub
   function [3:0] onehot;
      input [1:0] n;
      begin
         onehot = 4'h1 << n;
      end
   endfunction

   wire [3:0] m1 = onehot(main_ax);
   wire [3:0] s1 = onehot(sub_ax);

   // ****************************************
   // precondition evaluation
   // ****************************************
   // checks run in priority order; first failing one wins
   always @* begin
      code = `MPC_E_NONE;
      stop_set = 4'h0;
      start_set = 4'h0;
      switch_set = 4'h0;
      err_axes = 4'h0;
      case (op)
         `MPC_OP_LINEAR: begin
            err_axes = m1;
            if (main_ax == sub_ax)
               code = `MPC_E_PAIR;
            else if (|(ax_noout & m1))
               code = `MPC_E_MAIN_NOOUT;
            else if (|(ax_noout & s1))
               code = `MPC_E_SUB_NOOUT;
            else if (|(ax_aux & m1))
               code = `MPC_E_MAIN_AUX;
            else if (|(ax_aux & s1))
               code = `MPC_E_SUB_AUX;
            else if (|(ax_step_abs & m1) && !(|(ax_homed & s1)))
               code = absvar ? `MPC_E_ABS_ORG_B : `MPC_E_ABS_ORG_A;
            else if (|(ax_step_nomove & m1))
               code = `MPC_E_NOMOVE;
            else if (|(ax_step_spd & m1))
               code = `MPC_E_MAIN_SPD;
            else if (|(ax_step_spd & s1))
               code = `MPC_E_SUB_SPD;
            if (code != `MPC_E_NONE)
               stop_set = m1 | s1;
            else
               start_set = m1 | s1;
         end
         `MPC_OP_CONCUR: begin
            err_axes = cc_mask;
            // fewer than two axes is not a concurrent start
            if (cc_mask == 4'h0 || (cc_mask & (cc_mask - 4'h1)) == 4'h0)
               code = `MPC_E_CC_SET;
            else if (|(ax_busy & cc_mask))
               code = `MPC_E_CC_BUSY;
            else if (|(ax_noout & cc_mask))
               code = `MPC_E_CC_NOOUT;
            else if (|(ax_aux & cc_mask))
               code = `MPC_E_CC_AUX;
            else if (|(~ax_homed & cc_mask))
               code = `MPC_E_CC_ORG;
            // moving axes keep running: no stop for the busy case
            if (code == `MPC_E_NONE)
               start_set = cc_mask;
            else if (code != `MPC_E_CC_BUSY)
               stop_set = cc_mask & ~ax_busy;
         end
         `MPC_OP_SPDPOS: begin
            err_axes = m1;
            if (!(|(ax_busy & m1)))
               code = `MPC_E_SP_IDLE;
            else if (!(|(ax_spdctl & m1)))
               code = `MPC_E_SP_NOTSPD;
            else if (|(ax_step_nomove & m1))
               code = `MPC_E_SP_NOAMT;
            if (code != `MPC_E_NONE)
               stop_set = m1;
            else
               switch_set = m1;
         end
         default: begin
            code = `MPC_E_NONE;
         end
      endcase
   end

   // ****************************************
   // bus and command sequencing
   // ****************************************
   // a command write is evaluated in its ack cycle, one cycle after the
   // request, so the axis inputs are sampled after the word is stable
   wire wr_cmd = req & wb_we_i & (wb_adr_i == `MPC_OFF_CMD) & wb_sel_i[0];

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         cmd_reg <= 1'b0;
         cmd_word_reg <= 17'h0_0000;
      end else begin
         wb_ack_o <= req;
         cmd_reg <= wr_cmd;
         if (wr_cmd) begin
            cmd_word_reg[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
               cmd_word_reg[15:8] <= wb_dat_i[15:8];
            if (wb_sel_i[2])
               cmd_word_reg[16] <= wb_dat_i[16];
         end
         if (req & ~wb_we_i) begin
            case (wb_adr_i)
               `MPC_OFF_CMD: wb_dat_o <= {15'h0000, cmd_word_reg};
               `MPC_OFF_STAT: wb_dat_o <= {21'h00_0000, last_op_reg, last_err_reg};
               `MPC_OFF_AXST: wb_dat_o <= {12'h000, ax_spdctl, ax_homed, ax_aux,
                                           ax_noout, ax_busy};
               `MPC_OFF_ERR0: wb_dat_o <= {23'h00_0000, err_reg[0]};
               8'h14: wb_dat_o <= {23'h00_0000, err_reg[1]};
               8'h18: wb_dat_o <= {23'h00_0000, err_reg[2]};
               8'h1c: wb_dat_o <= {23'h00_0000, err_reg[3]};
               default: wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ****************************************
   // results and error latches
   // ****************************************
   // error latches clear on a write with wb_sel_i[0] set to their offset; a new error wins
   wire clr_err = req & wb_we_i & wb_sel_i[0] & (wb_adr_i[7:4] == 4'h1);
   wire [1:0] clr_idx = wb_adr_i[3:2];

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_err
         always @(posedge clk or posedge rst) begin
            if (rst)
               err_reg[g] <= `MPC_E_NONE;
            else if (cmd_reg && code != `MPC_E_NONE && err_axes[g])
               err_reg[g] <= code;
            else if (clr_err && clr_idx == g)
               err_reg[g] <= `MPC_E_NONE;
         end
      end
   endgenerate

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ax_start_reg <= 4'h0;
         ax_stop_reg <= 4'h0;
         ax_switch_reg <= 4'h0;
         err_pulse_reg <= 1'b0;
         last_err_reg <= `MPC_E_NONE;
         last_op_reg <= 2'h0;
      end else begin
         ax_start_reg <= cmd_reg ? start_set : 4'h0;
         ax_stop_reg <= cmd_reg ? stop_set : 4'h0;
         ax_switch_reg <= cmd_reg ? switch_set : 4'h0;
         err_pulse_reg <= cmd_reg && code != `MPC_E_NONE;
         if (cmd_reg) begin
            last_err_reg <= code;
            last_op_reg <= op;
         end
      end
   end

endmodule // mpc_checker

// File: verif/mpc_axis_model.sv
// axis-side stand-in: status levels set by the bench, plus motion state
// assumes start and stop pulses from mpc_checker on the same clock
`timescale 1ns/1ps
module mpc_axis_model (
   // clock and reset
   input wire clk,
   input wire rst,
   // bench levels: busy,noout,aux,homed,spdctl,step spd,abs,nomove
   input wire [31:0] cfg,
   // pulses from the checker
   input wire [3:0] start,
   input wire [3:0] stop,
   // axis status
   output wire [3:0] busy,
   output wire [3:0] noout,
   output wire [3:0] aux,
   output wire [3:0] homed,
   output wire [3:0] spdctl,
   output wire [3:0] step_spd,
   output wire [3:0] step_abs,
   output wire [3:0] step_nomove
);
   reg [3:0] run_reg;
   // a started axis keeps moving until told to stop, so later commands see it busy
   always @(posedge clk or posedge rst) begin
      if (rst)
         run_reg <= 4'h0;
      else
         run_reg <= (run_reg | start) & ~stop;
   end
   assign busy = cfg[3:0] | run_reg;
   assign noout = cfg[7:4];
   assign aux = cfg[11:8];
   assign homed = cfg[15:12];
   assign spdctl = cfg[19:16];
   assign step_spd = cfg[23:20];
   assign step_abs = cfg[27:24];
   assign step_nomove = cfg[31:28];
endmodule // mpc_axis_model

// File: verif/mpc_checker_asserts.sv
// properties on bus handshake and command outcomes of mpc_checker
// assumes the top-level ports only; rejection pulses one sample after ack
`timescale 1ns/1ps
module mpc_checker_asserts (
   input wire clk,
   input wire rst,
   input wire wb_stb_i,
   input wire wb_cyc_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire wb_ack_o,
   input wire [3:0] ax_busy,
   input wire [3:0] ax_noout,
   input wire [3:0] ax_aux,
   input wire [3:0] ax_homed,
   input wire [3:0] ax_spdctl,
   input wire [3:0] ax_step_spd,
   input wire [3:0] ax_step_abs,
   input wire [3:0] ax_step_nomove,
   input wire [3:0] ax_start_reg,
   input wire [3:0] ax_stop_reg,
   input wire [3:0] ax_switch_reg,
   input wire err_pulse_reg
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire cmd = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00;
   wire [1:0] m = wb_dat_i[5:4];
   wire [1:0] s = wb_dat_i[9:8];
   wire [3:0] mk = wb_dat_i[15:12];
   wire lin = cmd && wb_dat_i[1:0] == 2'h1;
   wire cc = cmd && wb_dat_i[1:0] == 2'h2;
   wire sp = cmd && wb_dat_i[1:0] == 2'h3;
   wire many = (mk & (mk - 4'h1)) != 4'h0;
   // bus fields are gone by the time the result shows, so hold them
   reg [1:0] m_q;
   reg [3:0] mk_q;
   always @(posedge clk) begin
      if (cmd) begin
         m_q <= m;
         mk_q <= mk;
      end
   end
   sequence s_rej;
      ##1 err_pulse_reg && ax_start_reg == 4'h0;
   endsequence
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
   property p_ack_resp;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("ack late");
   property p_pair;
      lin && m == s |-> s_rej ##0 ax_stop_reg[m_q];
   endproperty
   a_pair: assert property (p_pair) else $error("bad pair accepted");
   property p_lin_stop;
      lin && (ax_noout[m] || ax_noout[s] || ax_aux[m] || ax_aux[s]) |-> s_rej ##0 ax_stop_reg[m_q];
   endproperty
   a_lin_stop: assert property (p_lin_stop) else $error("linear lock missed");
   property p_lin_org;
      lin && ax_step_abs[m] && !ax_homed[s] |-> s_rej;
   endproperty
   a_lin_org: assert property (p_lin_org) else $error("unhomed sub accepted");
   property p_lin_step;
      lin && (ax_step_nomove[m] || ax_step_spd[m] || ax_step_spd[s]) |-> s_rej ##0 ax_stop_reg[m_q];
   endproperty
   a_lin_step: assert property (p_lin_step) else $error("bad step accepted");
   property p_cc_busy;
      cc && many && (mk & ax_busy) != 4'h0 |-> ##1 err_pulse_reg && ax_stop_reg == 4'h0;
   endproperty
   a_cc_busy: assert property (p_cc_busy) else $error("busy group wrong");
   property p_cc_rej;
      cc && many && (mk & ax_busy) == 4'h0 && (mk & (ax_noout | ax_aux | ~ax_homed)) != 4'h0
         |-> s_rej ##0 ax_stop_reg == mk_q;
   endproperty
   a_cc_rej: assert property (p_cc_rej) else $error("group lock missed");
   property p_cc_set;
      cc && !many |-> s_rej;
   endproperty
   a_cc_set: assert property (p_cc_set) else $error("group set accepted");
   property p_sp;
      sp && (!ax_busy[m] || !ax_spdctl[m] || ax_step_nomove[m])
         |-> s_rej ##0 ax_stop_reg[m_q] && ax_switch_reg == 4'h0;
   endproperty
   a_sp: assert property (p_sp) else $error("switch accepted");
endmodule // mpc_checker_asserts
bind mpc_checker mpc_checker_asserts mpc_checker_asserts_inst (.clk, .rst, .wb_stb_i, .wb_cyc_i,
   .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .ax_busy, .ax_noout, .ax_aux, .ax_homed,
   .ax_spdctl, .ax_step_spd, .ax_step_abs, .ax_step_nomove, .ax_start_reg, .ax_stop_reg,
   .ax_switch_reg, .err_pulse_reg);

// File: verif/mpc_checker_test.sv
// bench: commands over wishbone, axis levels through mpc_axis_model
// assumes 20 MHz clock and async active-high reset held 16 cycles
`timescale 1ns/1ps
module mpc_checker_test;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg cyc = 1'b0;
   reg we = 1'b0;
   reg [7:0] adr = 8'h00;
   reg [31:0] dat = 32'h0, cfg = 32'h0, rd;
   wire [31:0] dat_o;
   wire ack;
   wire [3:0] bsy, nout, aux, hmd, spc, sspd, sabs, snm, st, sp;
   integer bad_count = 0, check_count = 0, cycles = 0, i;
   initial forever #25 clk = ~clk;
   mpc_checker mpc_checker_inst (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .ax_busy(bsy), .ax_noout(nout), .ax_aux(aux), .ax_homed(hmd),
      .ax_spdctl(spc), .ax_step_spd(sspd), .ax_step_abs(sabs), .ax_step_nomove(snm),
      .ax_start_reg(st), .ax_stop_reg(sp), .ax_switch_reg(), .err_pulse_reg());
   mpc_axis_model mpc_axis_model_inst (.clk(clk), .rst(rst), .cfg(cfg), .start(st), .stop(sp),
      .busy(bsy), .noout(nout), .aux(aux), .homed(hmd), .spdctl(spc), .step_spd(sspd),
      .step_abs(sabs), .step_nomove(snm));
   task final_report;
      begin
         $display("checks %0d mismatches %0d", check_count, bad_count);
         if (bad_count == 0 && check_count > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         bad_count = bad_count + 1;
         final_report;
      end
   end
   task wb(input reg w, input reg [7:0] a, input reg [31:0] d);
      begin
         @(posedge clk);
         cyc <= 1'b1;
         {we, adr, dat} <= {w, a, d};
         @(posedge clk);
         while (ack !== 1'b1) @(posedge clk);
         rd = dat_o;
         cyc <= 1'b0;
      end
   endtask
   task chk(input string n, input reg [31:0] got, input reg [31:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("Error %s expected %h seen %h", n, exp, got);
         end
      end
   endtask
   task t(input reg [31:0] c, input reg [31:0] m, input reg [8:0] e, input reg [1:0] x);
      begin
         for (i = 0; i < 4; i = i + 1) wb(1'b1, {4'h1, i[1:0], 2'b00}, 32'h0);
         cfg <= c;
         wb(1'b1, 8'h00, m);
         wb(1'b0, 8'h04, 32'h0);
         chk("status code", rd & 32'h1ff, {23'h0, e});
         wb(1'b0, {4'h1, x, 2'b00}, 32'h0);
         chk("axis error", rd & 32'h1ff, {23'h0, e});
         $display("test command %h done", m);
      end
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      cfg <= 32'h0000f000;
      wb(1'b0, 8'h08, 32'h0);
      chk("axis state", rd, 32'h0000f000);
      wb(1'b0, 8'hfc, 32'h0);
      chk("unmapped", rd, 32'h0);
      t(32'h0000f000, 32'h101, 9'd0, 2'd0);
      t(32'h0000f000, 32'h3002, 9'd291, 2'd0);
      t(32'h0002f000, 32'h13, 9'd0, 2'd1);
      t(32'h2002f000, 32'h13, 9'd304, 2'd1);
      t(32'h0000f000, 32'h03, 9'd302, 2'd0);
      t(32'h0000f000, 32'h23, 9'd301, 2'd2);
      t(32'h0000f010, 32'h101, 9'd244, 2'd0);
      t(32'h0000f020, 32'h101, 9'd245, 2'd0);
      t(32'h0000f100, 32'h101, 9'd247, 2'd0);
      t(32'h0000f200, 32'h101, 9'd248, 2'd0);
      t(32'h0100d000, 32'h101, 9'd250, 2'd0);
      t(32'h0100d000, 32'h10101, 9'd251, 2'd0);
      t(32'h0000f000, 32'h331, 9'd253, 2'd3);
      t(32'h1000f000, 32'h101, 9'd257, 2'd0);
      t(32'h0010f000, 32'h101, 9'd258, 2'd0);
      t(32'h0020f000, 32'h101, 9'd259, 2'd0);
      t(32'h0000f040, 32'h6002, 9'd292, 2'd1);
      t(32'h0000f200, 32'h6002, 9'd293, 2'd1);
      t(32'h0000b000, 32'h6002, 9'd294, 2'd1);
      t(32'h0000f000, 32'h8002, 9'd296, 2'd3);
      final_report;
   end
endmodule // mpc_checker_test
